// >>> bench/bip_bb_src.sv
// Upstream baseband source model: interleaved I/Q words with frame strobe.
// Assumes its tasks are entered right after a rising edge of clk_i.
`timescale 1ns/10ps
module bip_bb_src (
    input wire logic clk_i,
    output logic bb_clk_o,
    output logic [15:0] bus_o,
    output logic frame_o,
    output logic [1:0] low_o
);
    // Idle pins, clock stands low outside groups
    initial begin
        bb_clk_o = 1'b0;
        bus_o = 16'h0000;
        frame_o = 1'b0;
        low_o = 2'h0;
    end
    // One word per baseband clock of 8 cycles
    task automatic send(input logic [17:0] w, input logic fr);
        bb_clk_o <= 1'b0;
        bus_o <= w[17:2];
        low_o <= w[1:0];
        frame_o <= fr; // Strobe rides the first I only
        repeat (4) @(posedge clk_i);
        bb_clk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    // One channel slot, I then Q
    task automatic pair(input logic [17:0] i, q, input logic fr);
        send(i, fr);
        send(q, 1'b0);
    endtask
    // After a group the lines no longer show the last word
    task automatic idle();
        bb_clk_o <= 1'b0;
        bus_o <= ~bus_o;
        low_o <= ~low_o;
        frame_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // bip_bb_src

// >>> bench/bip_chk.sv
// Port checker of the baseband input port: bus answers and output stream.
// Assumes it is bound to bip_top and sees its ports only.
`timescale 1ns/10ps
module bip_chk #(parameter int NUM_CH = 12) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic out_bypass_o,
    input wire logic [3:0] out_chan_o,
    input wire logic [17:0] out_i_o,
    input wire logic [17:0] out_q_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("bus answer late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer too long");
    ack_cause_a: assert property ($rose(wb_ack_o)
        |-> $past(wb_cyc_i && wb_stb_i)) else $error("answer unasked");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0) else $error("hole read");
    // Output stream
    out_hold_a: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable({out_chan_o,
        out_i_o, out_q_o, out_bypass_o})) else $error("word not held");
    chan_range_a: assert property (
        out_valid_o |-> out_chan_o < NUM_CH) else $error("bad channel");
    bypass_chan_a: assert property (
        out_valid_o && out_bypass_o |-> out_chan_o == 4'h0)
        else $error("bypass channel");
    reset_clean_a: assert property ($fell(rst_i) |-> !out_valid_o
        && !wb_ack_o && wb_dat_o == 32'h0) else $error("unclean reset");
    cover property (wb_ack_o && !wb_we_i);
    cover property (out_valid_o && out_ready_i && !out_bypass_o);
    cover property (out_valid_o && !out_ready_i ##1 out_ready_i);
endmodule // bip_chk

// >>> bench/testbench.sv
// Self-checking bench of bip_top: registers, channel split, gain, meters,
// bypass and output FIFO overflow. Assumes bip_bb_src as upstream source.
`timescale 1ns/10ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bb_clk, frm, ack, ov, obyp;
    logic [15:0] bus;
    logic [1:0] low;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ordy = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, wdo, got;
    logic [3:0] och;
    logic [17:0] oi, oq;
    int num_errors = 0, tests_run = 0;
    // 250 MHz clock
    initial forever #2 clk_i = ~clk_i;
    bip_bb_src i_bip_bb_src (.clk_i(clk_i), .bb_clk_o(bb_clk), .bus_o(bus),
        .frame_o(frm), .low_o(low));
    bip_top #(.NUM_CH(12)) i_bip_top (.clk_i(clk_i), .rst_i(rst_i),
        .bb_clk_i(bb_clk), .baseband_sample_bus_i(bus),
        .baseband_frame_strobe_i(frm), .multifunction_low_bits_i(low),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wdo), .wb_ack_o(ack),
        .out_valid_o(ov), .out_ready_i(ordy), .out_bypass_o(obyp),
        .out_chan_o(och), .out_i_o(oi), .out_q_o(oq));
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (ack !== 1'b1) num_errors++; // Bus answer never came
        got = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(got, e);
    endtask
    // Waits for the head word, compares it, then takes it
    task automatic pop(input logic [3:0] c, input logic [17:0] i, q,
                       input logic b);
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ov !== 1'b1 && n < 300);
        if (ov !== 1'b1) num_errors++; // Output word never came
        chk({obyp, och, oi}, {b, c, i});
        chk(oq, q);
        ordy <= 1'b1;
        @(posedge clk_i);
        ordy <= 1'b0;
    endtask
    task automatic final_report();
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 32'hC0);
        rd(8'h40, 32'h4000);
        rd(8'h10, 32'h18);
        rd(8'h0C, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h20, 32'h0);
        wb(1'b1, 8'h00, 32'h30);
        wb(1'b1, 8'h44, 32'h2000);
        wb(1'b1, 8'h04, 32'h1);
        i_bip_bb_src.pair(18'h00100, 18'h3FF80, 1'b1);
        i_bip_bb_src.pair(18'h01000, 18'h3FFFF, 1'b0);
        i_bip_bb_src.pair(18'h1FFFF, 18'h20000, 1'b0);
        i_bip_bb_src.pair(18'h00005, 18'h00007, 1'b0);
        i_bip_bb_src.idle();
        pop(4'h0, 18'h00100, 18'h3FF80, 1'b0);
        pop(4'h1, 18'h00800, 18'h3FFFF, 1'b0);
        pop(4'h2, 18'h1FFFF, 18'h20000, 1'b0);
        pop(4'h0, 18'h00005, 18'h00007, 1'b0);
        rd(8'h80, 32'h140);
        rd(8'h84, 32'h4000);
        wb(1'b1, 8'h04, 32'h2);
        rd(8'h80, 32'h0);
        rd(8'h84, 32'h0);
        wb(1'b1, 8'h10, 32'h4);
        wb(1'b0, 8'h08, 32'h0);
        chk(got[3:0], 4'h8);
        wb(1'b1, 8'h00, 32'h1);
        for (int k = 0; k < 34; k++)
            i_bip_bb_src.pair(18'(k), 18'(k + 256), 1'b1);
        i_bip_bb_src.idle();
        repeat (8) @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0);
        chk(got[0], 1'b1);
        for (int k = 0; k < 33; k++)
            pop(4'h0, 18'(k), 18'(k + 256), 1'b1);
        repeat (20) @(posedge clk_i);
        chk(ov, 1'b0);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk(got[0], 1'b0);
        // Second reset mid-run, then pilot add and a misplaced frame strobe
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 8'h0C, 32'h100);
        wb(1'b1, 8'h00, 32'h2);
        i_bip_bb_src.send(18'h00055, 1'b1);
        i_bip_bb_src.pair(18'h01000, 18'h00000, 1'b1);
        i_bip_bb_src.idle();
        pop(4'h0, 18'h00F00, 18'h3FF00, 1'b0);
        rd(8'h08, 32'h2);
        final_report();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        final_report();
    end
endmodule // testbench
bind bip_top bip_chk #(.NUM_CH(NUM_CH)) i_bip_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_bypass_o(out_bypass_o),
    .out_chan_o(out_chan_o), .out_i_o(out_i_o), .out_q_o(out_q_o));

// >>> pkg/bip_pkg.sv
// Constants, register map and stream word layout of the baseband input port.
// Assumes a single 250 MHz system clock and a byte-addressed Wishbone map.
package bip_pkg;
    // Clock rates in MHz and the least baseband clock period in cycles
    localparam int CLK_MHZ = 250;
    localparam int BB_MAX_MHZ = 93;
    localparam int BB_BYP_MHZ = 140;
    localparam int BB_BYP_CPLX_MHZ = BB_BYP_MHZ / 2;
    localparam int BB_MIN_CYC = (CLK_MHZ + BB_MAX_MHZ - 1) / BB_MAX_MHZ;
    localparam int BB_BYP_MIN_CYC = (CLK_MHZ + BB_BYP_MHZ - 1) / BB_BYP_MHZ;
    // Sample and channel widths
    localparam int SMP_W = 18;
    localparam int BUS_W = 16;
    localparam int LOW_W = 2;
    localparam int MAX_CH = 12;
    localparam int CH_W = 4;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 14;
    localparam int PWR_W = 40;
    localparam int PWR_SHIFT = 8;
    localparam int FIFO_DEPTH = 32;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_METER = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_PILOT = 8'h0C;
    localparam logic [7:0] ADR_INTERP = 8'h10;
    localparam logic [7:0] ADR_GAIN = 8'h40;
    localparam logic [7:0] ADR_POWER = 8'h80;
    // Field positions
    localparam int CTRL_BYP_BIT = 0;
    localparam int CTRL_PIL_BIT = 1;
    localparam int CTRL_NCH_LSB = 4;
    localparam int METER_RUN_BIT = 0;
    localparam int METER_CLR_BIT = 1;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_ALIGN_BIT = 1;
    localparam int STAT_RATE_BIT = 2;
    localparam int STAT_CFG_BIT = 3;
    localparam int STAT_CH_LSB = 8;
    // Reset values
    localparam logic [CH_W-1:0] NCH_RST = 4'hC;
    localparam logic [7:0] INTERP_RST = 8'h18;
    localparam logic [GAIN_W-1:0] GAIN_RST = 16'h4000;
    localparam logic [GAIN_W-1:0] PILOT_RST = 16'h0000;
    localparam logic [14:0] LFSR_SEED = 15'h7FFF;

    // One processed I/Q pair on its way to the upconverters
    typedef struct packed {
        logic byp;
        logic [CH_W-1:0] ch;
        logic [SMP_W-1:0] i;
        logic [SMP_W-1:0] q;
    } bip_word_s;
    localparam int WORD_W = $bits(bip_word_s);
endpackage

// >>> pkg/bip_stream_if.sv
// Valid/ready stream carrier between the port logic and its FIFO.
// Assumes source and sink share one clock.
`timescale 1ns/10ps
interface bip_stream_if #(parameter int W = bip_pkg::WORD_W);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// >>> rtl/bip_fifo.sv
// Synchronous FIFO with a registered read data stage.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/10ps
module bip_fifo #(
    parameter int W = bip_pkg::WORD_W,
    parameter int DEPTH = bip_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    bip_stream_if.snk wr,
    bip_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic out_v_q;
    logic [W-1:0] out_q;
    logic push;
    logic pop;

    // Full and pop conditions; the output stage refills when drained
    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign push = wr.valid & wr.ready;
    assign pop = (cnt_q != '0) & (~out_v_q | rd.ready);
    assign rd.valid = out_v_q;
    assign rd.data = out_q;

    // Storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_q] <= wr.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered head of queue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_v_q <= 1'b0;
            out_q <= '0;
        end else if (pop) begin
            out_v_q <= 1'b1;
            out_q <= mem[rp_q];
        end else if (rd.ready) begin
            out_v_q <= 1'b0;
        end
    end
endmodule // bip_fifo

// >>> rtl/bip_top.sv
// Baseband I/Q input port: pin capture, channel split, per-channel gain,
// pilot insertion, power meters and an output FIFO to the upconverters.
// Assumes a classic Wishbone master on clk_i and baseband pins that are
// asynchronous to clk_i, with the baseband clock seen as a sampled pin.
// Summary of operation
// - Normal mode: interleaved I/Q words, baseband clock up to 93 MHz.
// - Up to twelve carriers share the sample bus.
// - All channel I/Q words must fit in one interpolation period.
// - Bypass sends raw I/Q onward, clock up to 140 MHz.
// - Samples are 18 bits: sixteen on bus, two on multifunction pins.
// - Normal mode splits the stream into channels for the upconverters.
// - Each carrier gets its own programmable gain.
// - A pilot sequence scaled by a programmable gain may be added.
// - Each channel accumulates I squared plus Q squared.
// - One shared control runs and clears all power meters.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module bip_top #(
    parameter int NUM_CH = bip_pkg::MAX_CH,
    parameter int FIFO_DEPTH = bip_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bb_clk_i,
    input wire logic [bip_pkg::BUS_W-1:0] baseband_sample_bus_i,
    input wire logic baseband_frame_strobe_i,
    input wire logic [bip_pkg::LOW_W-1:0] multifunction_low_bits_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic out_bypass_o,
    output logic [bip_pkg::CH_W-1:0] out_chan_o,
    output logic [bip_pkg::SMP_W-1:0] out_i_o,
    output logic [bip_pkg::SMP_W-1:0] out_q_o
);
    localparam int SMP_W = bip_pkg::SMP_W;
    localparam int CH_W = bip_pkg::CH_W;
    localparam int PWR_W = bip_pkg::PWR_W;
    localparam int SYNC_W = 2 + bip_pkg::BUS_W + bip_pkg::LOW_W;

    // Byte-lane merge of a write into an old register value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
        return old;
    endfunction

    // Gain, pilot add and saturation to the sample width
    function automatic logic [SMP_W-1:0] shape(
        input logic signed [SMP_W-1:0] x,
        input logic [bip_pkg::GAIN_W-1:0] g,
        input logic signed [SMP_W-1:0] p);
        logic signed [2*SMP_W-1:0] prod;
        logic signed [2*SMP_W-1:0] sum;
        prod = x * $signed({2'h0, g});
        sum = (prod >>> bip_pkg::GAIN_FRAC) + (2*SMP_W)'(p);
        if (sum > 36'sh1FFFF) begin
            return 18'h1FFFF;
        end else if (sum < -36'sh20000) begin
            return 18'h20000;
        end
        return sum[SMP_W-1:0];
    endfunction

    // Square of a sample at accumulator width
    function automatic logic [PWR_W-1:0] sq(input logic signed [SMP_W-1:0] x);
        logic signed [2*SMP_W-1:0] p;
        p = x * x;
        return {{(PWR_W-2*SMP_W){1'b0}}, p};
    endfunction

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync3_q;
    logic bbclk_lvl_q;
    logic word_stb;
    logic word_frame;
    logic [SMP_W-1:0] word;
    logic [3:0] gap_q;
    logic [3:0] min_gap;
    logic ctrl_byp_q;
    logic ctrl_pil_q;
    logic [CH_W-1:0] ctrl_nch_q;
    logic [7:0] interp_q;
    logic [bip_pkg::GAIN_W-1:0] pil_gain_q;
    logic meter_run_q;
    logic [bip_pkg::GAIN_W-1:0] gain_q [NUM_CH];
    logic [PWR_W-1:0] pwr_q [NUM_CH];
    logic ovf_q;
    logic align_q;
    logic rate_q;
    logic cfg_err;
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic wb_wr;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [31:0] clr_word;
    logic [7:0] gain_off;
    logic [7:0] pwr_off;
    logic gain_hit;
    logic pwr_hit;
    logic [CH_W-1:0] gain_idx;
    logic [CH_W-1:0] pwr_idx;
    logic meter_clr;
    logic ph_q;
    logic [CH_W-1:0] ch_q;
    logic [SMP_W-1:0] ihold_q;
    logic pair_v_q;
    logic pair_byp_q;
    logic [CH_W-1:0] pair_ch_q;
    logic [SMP_W-1:0] pair_i_q;
    logic [SMP_W-1:0] pair_q_q;
    logic [14:0] lfsr_q;
    logic signed [SMP_W-1:0] pil_i;
    logic signed [SMP_W-1:0] pil_q;
    logic st_v_q;
    logic st_byp_q;
    logic [CH_W-1:0] st_ch_q;
    logic [SMP_W-1:0] st_i_q;
    logic [SMP_W-1:0] st_q_q;
    logic [PWR_W:0] pwr_sum;
    bip_pkg::bip_word_s out_word;

    bip_stream_if #(.W(bip_pkg::WORD_W)) fifo_in ();
    bip_stream_if #(.W(bip_pkg::WORD_W)) fifo_out ();

    // Three-stage capture of the asynchronous baseband pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {bb_clk_i, baseband_frame_strobe_i,
                        baseband_sample_bus_i, multifunction_low_bits_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Baseband clock level follows only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bbclk_lvl_q <= 1'b0;
        end else if (sync2_q[SYNC_W-1] == sync3_q[SYNC_W-1]) begin
            bbclk_lvl_q <= sync3_q[SYNC_W-1];
        end
    end

    // One word per baseband rising edge; 16 bus bits on top of 2 low bits
    assign word_stb = sync2_q[SYNC_W-1] & sync3_q[SYNC_W-1] & ~bbclk_lvl_q;
    assign word_frame = sync3_q[SYNC_W-2];
    assign word = sync3_q[SMP_W-1:0];

    // Least edge spacing depends on mode: 93 MHz normal, 140 MHz bypass
    assign min_gap = ctrl_byp_q ? 4'(bip_pkg::BB_BYP_MIN_CYC)
                                : 4'(bip_pkg::BB_MIN_CYC);

    // Cycles since the last baseband edge, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_q <= '1;
        end else if (word_stb) begin
            gap_q <= '0;
        end else if (gap_q != '1) begin
            gap_q <= gap_q + 4'h1;
        end
    end

    // All I and Q words of the active channels must fit the period
    assign cfg_err = ~ctrl_byp_q &
                     ({3'h0, ctrl_nch_q, 1'b0} > interp_q);

    // Wishbone decode of the gain and power windows
    assign gain_off = wb_adr_i - bip_pkg::ADR_GAIN;
    assign pwr_off = wb_adr_i - bip_pkg::ADR_POWER;
    assign gain_hit = (gain_off < 8'(4*NUM_CH)) && (gain_off[1:0] == 2'h0);
    assign pwr_hit = (pwr_off < 8'(4*NUM_CH)) && (pwr_off[1:0] == 2'h0);
    assign gain_idx = gain_off[CH_W+1:2];
    assign pwr_idx = pwr_off[CH_W+1:2];
    assign wb_wr = wb_ack_q & wb_cyc_i & wb_stb_i & wb_we_i;
    assign wr_word = merge(rd_word, wb_dat_i, wb_sel_i);
    assign clr_word = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    assign meter_clr = wb_wr & (wb_adr_i == bip_pkg::ADR_METER) &
                       wr_word[bip_pkg::METER_CLR_BIT];

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (gain_hit) begin
            rd_word[bip_pkg::GAIN_W-1:0] = gain_q[gain_idx];
        end else if (pwr_hit) begin
            rd_word = pwr_q[pwr_idx][bip_pkg::PWR_SHIFT +: 32];
        end else begin
            unique case (wb_adr_i)
                bip_pkg::ADR_CTRL: begin
                    rd_word[bip_pkg::CTRL_BYP_BIT] = ctrl_byp_q;
                    rd_word[bip_pkg::CTRL_PIL_BIT] = ctrl_pil_q;
                    rd_word[bip_pkg::CTRL_NCH_LSB +: CH_W] = ctrl_nch_q;
                end
                bip_pkg::ADR_METER: begin
                    rd_word[bip_pkg::METER_RUN_BIT] = meter_run_q;
                end
                bip_pkg::ADR_STATUS: begin
                    rd_word[bip_pkg::STAT_OVF_BIT] = ovf_q;
                    rd_word[bip_pkg::STAT_ALIGN_BIT] = align_q;
                    rd_word[bip_pkg::STAT_RATE_BIT] = rate_q;
                    rd_word[bip_pkg::STAT_CFG_BIT] = cfg_err;
                    rd_word[bip_pkg::STAT_CH_LSB +: CH_W] = ch_q;
                end
                bip_pkg::ADR_PILOT: begin
                    rd_word[bip_pkg::GAIN_W-1:0] = pil_gain_q;
                end
                bip_pkg::ADR_INTERP: begin
                    rd_word[7:0] = interp_q;
                end
                default: begin
                    rd_word = 32'h0000_0000;
                end
            endcase
        end
    end

    // Acknowledge one cycle after the request, read data registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= '0;
        end else begin
            wb_ack_q <= wb_cyc_i & wb_stb_i & ~wb_ack_q;
            if (wb_cyc_i & wb_stb_i & ~wb_ack_q) begin
                wb_dat_q <= rd_word;
            end
        end
    end
    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;

    // Control registers; writes land on the acknowledged edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_byp_q <= 1'b0;
            ctrl_pil_q <= 1'b0;
            ctrl_nch_q <= bip_pkg::NCH_RST;
            interp_q <= bip_pkg::INTERP_RST;
            pil_gain_q <= bip_pkg::PILOT_RST;
            meter_run_q <= 1'b0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                bip_pkg::ADR_CTRL: begin
                    ctrl_byp_q <= wr_word[bip_pkg::CTRL_BYP_BIT];
                    ctrl_pil_q <= wr_word[bip_pkg::CTRL_PIL_BIT];
                    ctrl_nch_q <= wr_word[bip_pkg::CTRL_NCH_LSB +: CH_W];
                end
                bip_pkg::ADR_METER: begin
                    meter_run_q <= wr_word[bip_pkg::METER_RUN_BIT];
                end
                bip_pkg::ADR_PILOT: begin
                    pil_gain_q <= wr_word[bip_pkg::GAIN_W-1:0];
                end
                bip_pkg::ADR_INTERP: begin
                    interp_q <= wr_word[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Per-carrier gain table
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                gain_q[c] <= bip_pkg::GAIN_RST;
            end
        end else if (wb_wr && gain_hit) begin
            gain_q[gain_idx] <= wr_word[bip_pkg::GAIN_W-1:0];
        end
    end

    // Sticky status flags, write one to clear; a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
            align_q <= 1'b0;
            rate_q <= 1'b0;
        end else begin
            ovf_q <= (ovf_q & ~(wb_wr & (wb_adr_i == bip_pkg::ADR_STATUS) &
                      clr_word[bip_pkg::STAT_OVF_BIT])) |
                     (st_v_q & ~fifo_in.ready);
            align_q <= (align_q & ~(wb_wr & (wb_adr_i == bip_pkg::ADR_STATUS) &
                        clr_word[bip_pkg::STAT_ALIGN_BIT])) |
                       (word_stb & word_frame & ph_q);
            rate_q <= (rate_q & ~(wb_wr & (wb_adr_i == bip_pkg::ADR_STATUS) &
                       clr_word[bip_pkg::STAT_RATE_BIT])) |
                      (word_stb & (gap_q < min_gap - 4'h1));
        end
    end

    // Deinterleave: frame restarts at channel 0 with an I word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= 1'b0;
            ch_q <= '0;
            ihold_q <= '0;
            pair_v_q <= 1'b0;
            pair_byp_q <= 1'b0;
            pair_ch_q <= '0;
            pair_i_q <= '0;
            pair_q_q <= '0;
        end else begin
            pair_v_q <= 1'b0;
            if (word_stb) begin
                if (word_frame || !ph_q) begin
                    ihold_q <= word;
                    ph_q <= 1'b1;
                    if (word_frame) begin
                        ch_q <= '0;
                    end
                end else begin
                    ph_q <= 1'b0;
                    pair_v_q <= 1'b1;
                    pair_byp_q <= ctrl_byp_q;
                    pair_ch_q <= ch_q;
                    pair_i_q <= ihold_q;
                    pair_q_q <= word;
                    if (ctrl_byp_q || ch_q + 4'h1 >= ctrl_nch_q ||
                        ch_q + 4'h1 >= CH_W'(NUM_CH)) begin
                        ch_q <= '0;
                    end else begin
                        ch_q <= ch_q + 4'h1;
                    end
                end
            end
        end
    end

    // Pilot sequence generator, one step per I/Q pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_q <= bip_pkg::LFSR_SEED;
        end else if (pair_v_q) begin
            lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
        end
    end

    // Pilot symbol scaled by its gain, zero when disabled
    assign pil_i = !ctrl_pil_q ? '0 : lfsr_q[0] ? -$signed({2'h0, pil_gain_q})
                                               : $signed({2'h0, pil_gain_q});
    assign pil_q = !ctrl_pil_q ? '0 : lfsr_q[1] ? -$signed({2'h0, pil_gain_q})
                                               : $signed({2'h0, pil_gain_q});

    // Gain and pilot stage; bypass passes the pair untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_v_q <= 1'b0;
            st_byp_q <= 1'b0;
            st_ch_q <= '0;
            st_i_q <= '0;
            st_q_q <= '0;
        end else begin
            st_v_q <= pair_v_q;
            if (pair_v_q) begin
                st_byp_q <= pair_byp_q;
                st_ch_q <= pair_ch_q;
                if (pair_byp_q) begin
                    st_i_q <= pair_i_q;
                    st_q_q <= pair_q_q;
                end else begin
                    st_i_q <= shape(pair_i_q, gain_q[pair_ch_q],
                                    pil_i);
                    st_q_q <= shape(pair_q_q, gain_q[pair_ch_q],
                                    pil_q);
                end
            end
        end
    end

    // Power accumulators, saturating, under the shared run and clear
    assign pwr_sum = {1'b0, pwr_q[st_ch_q]} +
                     {1'b0, sq(st_i_q) + sq(st_q_q)};
    always_ff @(posedge clk_i) begin
        if (rst_i || meter_clr) begin
            for (int c = 0; c < NUM_CH; c++) begin
                pwr_q[c] <= '0;
            end
        end else if (st_v_q && meter_run_q && !st_byp_q) begin
            pwr_q[st_ch_q] <= pwr_sum[PWR_W] ? '1
                                             : pwr_sum[PWR_W-1:0];
        end
    end

    // Output FIFO towards the upconverters
    assign fifo_in.valid = st_v_q;
    assign fifo_in.data = {st_byp_q, st_ch_q, st_i_q, st_q_q};
    assign fifo_out.ready = out_ready_i;
    assign out_word = fifo_out.data;
    assign out_valid_o = fifo_out.valid;
    assign out_bypass_o = out_word.byp;
    assign out_chan_o = out_word.ch;
    assign out_i_o = out_word.i;
    assign out_q_o = out_word.q;

    bip_fifo #(
        .W(bip_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr(fifo_in.snk),
        .rd(fifo_out.src)
    );
endmodule // bip_top
